// ==== common/tsbd_pkg.sv ====
package tsbd_pkg;
	// register byte addresses on the bus
	localparam logic [11:0] TSBD_TEST_SIGNAL_CONFIG_ADDR = 12'h008;
	localparam logic [11:0] TSBD_REF_BIAS_CONFIG_ADDR = 12'h00C;
	localparam logic [11:0] TSBD_IRQ_STATUS_ADDR = 12'h010;
	localparam logic [11:0] TSBD_IRQ_ENABLE_ADDR = 12'h014;
	localparam logic [11:0] TSBD_IRQ_CLEAR_ADDR = 12'h018;
	// register indices
	localparam int TSBD_TEST_SIGNAL_CONFIG_IDX = 2;
	localparam int TSBD_REF_BIAS_CONFIG_IDX = 3;
	// reset values
	localparam logic [7:0] TSBD_TEST_SIGNAL_CONFIG_RST = 8'h00;
	localparam logic [7:0] TSBD_REF_BIAS_CONFIG_RST = 8'h40;
	// test signal config fields
	localparam int TSBD_FREQ_LSB = 0;
	localparam int TSBD_AMP_BIT = 2;
	localparam int TSBD_INT_TEST_BIT = 4;
	localparam int TSBD_FIXED_ONE_BIT = 5;
	localparam logic [7:0] TSBD_TEST_WRITABLE_MASK = 8'h37;
	// reference and bias config fields
	localparam int TSBD_SENSE_BIT = 1;
	localparam int TSBD_BIAS_BUF_BIT = 2;
	localparam int TSBD_BIAS_REF_BIT = 3;
	localparam int TSBD_MEAS_BIT = 4;
	localparam int TSBD_VREF_BIT = 5;
	localparam int TSBD_REFBUF_BIT = 7;
	localparam logic [7:0] TSBD_REF_WRITABLE_MASK = 8'hBE;
	// frequency codes
	localparam logic [1:0] TSBD_FREQ_DIV21 = 2'h0;
	localparam logic [1:0] TSBD_FREQ_DIV20 = 2'h1;
	localparam logic [1:0] TSBD_FREQ_UNUSED = 2'h2;
	localparam logic [1:0] TSBD_FREQ_DC = 2'h3;
	localparam logic [2:0] TSBD_MUX_BIAS_MEAS = 3'h2;
	// divider width: period 2^21 needs a 21-bit counter
	localparam int TSBD_DIV_W = 21;
	// interrupt event bits
	localparam int TSBD_IRQ_W = 2;
	localparam int TSBD_EV_DISC = 0;
	localparam int TSBD_EV_CONN = 1;
	localparam int TSBD_NUM_CH = 8;
endpackage

// ==== core/tsbd_test_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsbd_test_gen
	import tsbd_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic [1:0] freq_sel, // frequency code
	output logic wave // square wave
);
	logic [TSBD_DIV_W-1:0] cnt_q;
	logic wave_d;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// msb of counter gives 50 percent duty over full period
	always_comb begin
		wave_d = 1'b0;
		unique case (freq_sel)
			TSBD_FREQ_DIV21: wave_d = cnt_q[TSBD_DIV_W-1];
			TSBD_FREQ_DIV20: wave_d = cnt_q[TSBD_DIV_W-2];
			TSBD_FREQ_UNUSED: wave_d = 1'b0;
			TSBD_FREQ_DC: wave_d = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave <= 1'b0;
		end else begin
			wave <= wave_d;
		end
	end
endmodule
`default_nettype wire

// ==== core/tsbd_regs.sv ====
// Function
// - test source bit: 0 external, 1 internal
// - frequency code selects divide, dc, unused
// - amplitude bit doubles test amplitude
// - bit 5 resets 0, host writes 1
// - bias register bit 6 reads 1
// - reference buffer enabled only when bit set
// - measure bit routes bias input to mux 010
// - bias reference external or internal midpoint
// - bias buffer enabled only when bit set
// - bias lead sensing follows enable bit
// - disconnected status read-only from hardware
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tsbd_regs
	import tsbd_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic bias_lead_off_in, // lead sense comparator, 1 = off
	input wire logic [2:0] channel_mux [TSBD_NUM_CH], // channel input selectors
	output logic test_internal, // test signal generated inside
	output logic test_amplitude_double, // twice amplitude
	output logic [1:0] test_frequency_select, // frequency code
	output logic test_wave, // internal test waveform
	output logic reference_buffer_enable, // reference buffer on
	output logic high_reference_select, // 4V reference
	output logic bias_measure_route, // measure bit
	output logic [TSBD_NUM_CH-1:0] bias_route_to_channel, // bias input to channel
	output logic bias_reference_internal, // internal midpoint
	output logic bias_buffer_enable, // bias buffer on
	output logic bias_lead_sense_enable, // lead sensing on
	output logic bias_lead_disconnected, // status bit
	output logic irq // interrupt level
);
	////////////////////////////////////////////////////////////////
	logic [7:0] test_cfg_q;
	logic [7:0] ref_cfg_q;
	logic stat_q;
	logic [TSBD_IRQ_W-1:0] irq_stat_q;
	logic [TSBD_IRQ_W-1:0] irq_stat_d;
	logic [TSBD_IRQ_W-1:0] irq_en_q;
	logic [31:0] prdata_d;

	wire access = psel && penable;
	wire wr = access && pwrite;
	wire sel_test = paddr == TSBD_TEST_SIGNAL_CONFIG_ADDR;
	wire sel_ref = paddr == TSBD_REF_BIAS_CONFIG_ADDR;
	wire sel_ist = paddr == TSBD_IRQ_STATUS_ADDR;
	wire sel_ien = paddr == TSBD_IRQ_ENABLE_ADDR;
	wire sel_icl = paddr == TSBD_IRQ_CLEAR_ADDR;
	wire mapped = sel_test || sel_ref || sel_ist || sel_ien || sel_icl;
	wire [7:0] wr_byte = pwdata[7:0];
	// reserved bits of the test register stay zero; bit 5 takes what host writes
	wire [7:0] test_cfg_wr = wr_byte & TSBD_TEST_WRITABLE_MASK;
	// bit 6 stays one, bit 0 is status only
	wire [7:0] ref_cfg_wr = (wr_byte & TSBD_REF_WRITABLE_MASK)
		| TSBD_REF_BIAS_CONFIG_RST;
	wire [7:0] ref_cfg_view = {ref_cfg_q[7:1], stat_q};
	// next status value; events are its edges, so a gated-off lead raises nothing
	wire stat_d = bias_lead_off_in && ref_cfg_q[TSBD_SENSE_BIT];
	wire [TSBD_IRQ_W-1:0] ev;
	assign ev[TSBD_EV_DISC] = stat_d && !stat_q;
	assign ev[TSBD_EV_CONN] = !stat_d && stat_q;
	wire [TSBD_IRQ_W-1:0] clr = (wr && sel_icl) ? pwdata[TSBD_IRQ_W-1:0] : '0;

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_cfg_q <= TSBD_TEST_SIGNAL_CONFIG_RST;
		end else if (wr && sel_test) begin
			test_cfg_q <= test_cfg_wr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cfg_q <= TSBD_REF_BIAS_CONFIG_RST;
		end else if (wr && sel_ref) begin
			ref_cfg_q <= ref_cfg_wr;
		end
	end

	// status follows hardware only; sensing gates the comparator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
		end
	end

	// set wins over clear
	assign irq_stat_d = (irq_stat_q & ~clr) | ev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (wr && sel_ien) begin
				irq_en_q <= pwdata[TSBD_IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	////////////////////////////////////////////////////////////////
	always_comb begin
		prdata_d = 32'h00000000;
		if (sel_test) prdata_d = {24'h000000, test_cfg_q};
		if (sel_ref) prdata_d = {24'h000000, ref_cfg_view};
		if (sel_ist) prdata_d = {30'h00000000, irq_stat_q};
		if (sel_ien) prdata_d = {30'h00000000, irq_en_q};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= prdata_d;
		end
	end

	////////////////////////////////////////////////////////////////
	logic gen_wave;
	tsbd_test_gen u_gen (
		.pclk(pclk),
		.presetn(presetn),
		.freq_sel(test_cfg_q[TSBD_FREQ_LSB +: 2]),
		.wave(gen_wave)
	);

	assign test_internal = test_cfg_q[TSBD_INT_TEST_BIT];
	assign test_amplitude_double = test_cfg_q[TSBD_AMP_BIT];
	assign test_frequency_select = test_cfg_q[TSBD_FREQ_LSB +: 2];
	assign test_wave = test_internal && gen_wave;
	assign reference_buffer_enable = ref_cfg_q[TSBD_REFBUF_BIT];
	assign high_reference_select = ref_cfg_q[TSBD_VREF_BIT];
	assign bias_measure_route = ref_cfg_q[TSBD_MEAS_BIT];
	assign bias_reference_internal = ref_cfg_q[TSBD_BIAS_REF_BIT];
	assign bias_buffer_enable = ref_cfg_q[TSBD_BIAS_BUF_BIT];
	assign bias_lead_sense_enable = ref_cfg_q[TSBD_SENSE_BIT];
	assign bias_lead_disconnected = stat_q;

	wire [TSBD_NUM_CH-1:0] route_w;
	genvar gi;
	generate
		for (gi = 0; gi < TSBD_NUM_CH; gi++) begin : g_route
			assign route_w[gi] = bias_measure_route
				&& (channel_mux[gi] == TSBD_MUX_BIAS_MEAS);
		end
	endgenerate
	assign bias_route_to_channel = route_w;

	////////////////////////////////////////////////////////////////
	// assertion helper: cycles since the generator output moved or was reprogrammed
	logic gen_wave_q;
	logic [TSBD_DIV_W-1:0] run_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_wave_q <= 1'b0;
			run_q <= '0;
		end else begin
			gen_wave_q <= gen_wave;
			if ((gen_wave != gen_wave_q) || (wr && sel_test)) begin
				run_q <= '0;
			end else if (run_q != {TSBD_DIV_W{1'b1}}) begin
				run_q <= run_q + 1'b1;
			end
		end
	end
	// half period plus the register delay of the first half after reset
	wire [TSBD_DIV_W-1:0] half21_max = {1'b1, {(TSBD_DIV_W-2){1'b0}}, 1'b1};
	wire [TSBD_DIV_W-1:0] half20_max = {2'b01, {(TSBD_DIV_W-3){1'b0}}, 1'b1};

	////////////////////////////////////////////////////////////////
	AST_TEST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
		(test_cfg_q[7:6] == 2'h0)
		&& !test_cfg_q[3])
		else $error("test config reserved bit set");
	AST_REF_BIT6: assert property (@(posedge pclk) disable iff (!presetn)
		ref_cfg_q[6]
		== 1'b1)
		else $error("bias config bit 6 not one");
	AST_TEST_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_test
		|=> test_cfg_q == ($past(pwdata[7:0]) & 8'h37))
		else $error("test config write lost");
	AST_REF_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_ref |=> reference_buffer_enable == $past(pwdata[7])
			&& bias_buffer_enable == $past(pwdata[2]))
		else $error("bias config write lost");
	AST_STAT_RO: assert property (@(posedge pclk) disable iff (!presetn)
		bias_lead_disconnected
		== $past(bias_lead_off_in && bias_lead_sense_enable))
		else $error("status not from hardware");
	AST_DC_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		test_internal && test_frequency_select == 2'h3 ##1
		$stable(test_frequency_select) && test_internal |-> test_wave)
		else $error("dc level missing");
	AST_EXT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!test_internal
		|-> !test_wave)
		else $error("internal wave while external");
	AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
		!bias_measure_route
		|-> bias_route_to_channel == 8'h00)
		else $error("bias routed while open");
	AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
		ev[TSBD_EV_DISC]
		|=> irq_stat_q[TSBD_EV_DISC])
		else $error("event lost");
	AST_TEST_INT_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_test
		|=> test_internal == $past(pwdata[4]))
		else $error("test source write lost");
	AST_TEST_AMPLITUDE_DOUBLE_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_test
		|=> test_amplitude_double == $past(pwdata[2]))
		else $error("amplitude write lost");
	AST_TEST_FREQUENCY_SELECT_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_test
		|=> test_frequency_select == $past(pwdata[1:0]))
		else $error("frequency write lost");
	AST_TEST_FIXED_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_test
		|=> test_cfg_q[5] == $past(pwdata[5]))
		else $error("test config bit 5 write lost");
	AST_TEST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && sel_test)
		|=> $stable(test_cfg_q))
		else $error("test config changed without write");
	AST_REF_VREF_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_ref
		|=> high_reference_select == $past(pwdata[5]))
		else $error("reference select write lost");
	AST_REF_MEAS_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_ref
		|=> bias_measure_route == $past(pwdata[4]))
		else $error("measure route write lost");
	AST_REF_BREF_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_ref
		|=> bias_reference_internal == $past(pwdata[3]))
		else $error("bias reference write lost");
	AST_REF_SENSE_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_ref
		|=> bias_lead_sense_enable == $past(pwdata[1]))
		else $error("sense enable write lost");
	AST_REF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && sel_ref)
		|=> $stable(ref_cfg_q))
		else $error("bias config changed without write");
	AST_STAT_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_ref
		|=> bias_lead_disconnected == $past(stat_d))
		else $error("status altered by write");
	AST_UNUSED_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		test_internal && test_frequency_select == 2'h2 ##1
		$stable(test_frequency_select) && test_internal |-> !test_wave)
		else $error("unused code drives wave");
	AST_PULSE_DIV21: assert property (@(posedge pclk) disable iff (!presetn)
		test_frequency_select == TSBD_FREQ_DIV21
		|-> run_q <= half21_max)
		else $error("slow pulse half period too long");
	AST_PULSE_DIV20: assert property (@(posedge pclk) disable iff (!presetn)
		test_frequency_select == TSBD_FREQ_DIV20
		|-> run_q <= half20_max)
		else $error("fast pulse half period too long");
	AST_ROUTE_CH0: assert property (@(posedge pclk) disable iff (!presetn)
		bias_measure_route && channel_mux[0] == TSBD_MUX_BIAS_MEAS
		|-> bias_route_to_channel[0])
		else $error("bias not routed to selected channel");
	AST_ROUTE_OTHER: assert property (@(posedge pclk) disable iff (!presetn)
		channel_mux[TSBD_NUM_CH-1] != TSBD_MUX_BIAS_MEAS
		|-> !bias_route_to_channel[TSBD_NUM_CH-1])
		else $error("bias routed to unselected channel");
	AST_IRQ_CONN: assert property (@(posedge pclk) disable iff (!presetn)
		ev[TSBD_EV_CONN]
		|=> irq_stat_q[TSBD_EV_CONN])
		else $error("reconnect event lost");
	AST_IRQ_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_icl && pwdata[TSBD_EV_DISC] && !ev[TSBD_EV_DISC]
		|=> !irq_stat_q[TSBD_EV_DISC])
		else $error("status clear lost");
	AST_IEN_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel_ien
		|=> irq_en_q == $past(pwdata[TSBD_IRQ_W-1:0]))
		else $error("interrupt enable write lost");
	AST_RD_REF: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && sel_ref
		|=> prdata == {24'h000000, $past(ref_cfg_view)})
		else $error("bias config read data wrong");
	AST_RD_TEST: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && sel_test
		|=> prdata == {24'h000000, $past(test_cfg_q)})
		else $error("test config read data wrong");
endmodule
`default_nettype wire

// ==== verification/tsbd_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsbd_host
	import tsbd_pkg::*;
(
	input wire logic pclk, // bus clock
	output logic psel, // select
	output logic penable, // enable
	output logic pwrite, // direction
	output logic [11:0] paddr, // address
	output logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr // error
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// raw skips the host's fixed-bit discipline, for refusal scenarios
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input bit raw,
		output logic [31:0] q, output logic err, output bit ok);
		logic [31:0] v;
		v = d;
		if (!raw && a == TSBD_TEST_SIGNAL_CONFIG_ADDR) v = (d & 32'h37) | 32'h20;
		if (!raw && a == TSBD_REF_BIAS_CONFIG_ADDR) v = d | 32'h40;
		ok = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 16 && !ok; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				ok = 1'b1;
				q = prdata;
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~v;
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_test_signal_and_bias_drive_config.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_test_signal_and_bias_drive_config
	import tsbd_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, off_in = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, re, irq, wave;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rq, l;
	logic [2:0] mux [TSBD_NUM_CH];
	logic [7:0] route, t_m, b_m;
	logic t_int, t_amp, rb_en, hi_ref, meas, b_int, b_buf, sense, disc;
	logic [1:0] t_freq;
	bit ok, raw;
	int mismatches = 0, total_checks = 0;
	always #5 pclk = ~pclk;
	tsbd_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	tsbd_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bias_lead_off_in(off_in), .channel_mux(mux), .test_internal(t_int),
		.test_amplitude_double(t_amp), .test_frequency_select(t_freq), .test_wave(wave),
		.reference_buffer_enable(rb_en), .high_reference_select(hi_ref),
		.bias_measure_route(meas), .bias_route_to_channel(route), .bias_reference_internal(b_int),
		.bias_buffer_enable(b_buf), .bias_lead_sense_enable(sense),
		.bias_lead_disconnected(disc), .irq(irq));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input bit r);
		host.xfer(w, a, d, r, rq, re, ok);
		if (!ok) begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic outs();
		logic [7:0] er;
		@(posedge pclk);
		#1;
		for (int i = 0; i < TSBD_NUM_CH; i++) er[i] = b_m[4] && mux[i] == 3'h2;
		chk("test_cfg_out", {t_int, t_amp, t_freq}, {t_m[4], t_m[2], t_m[1:0]});
		chk("bias_cfg_out", {rb_en, hi_ref, meas, b_int, b_buf, sense}, {b_m[7], b_m[5:1]});
		chk("route", route, er);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#900us;
		mismatches++;
		finish_test();
	end
	initial begin
		for (int i = 0; i < TSBD_NUM_CH; i++) mux[i] = 3'h0;
		l = 32'h8EB8;
		t_m = 8'h00;
		b_m = 8'h40;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		bus(1'b0, TSBD_TEST_SIGNAL_CONFIG_ADDR, 32'h0, 1'b0);
		chk("test_cfg_rst", rq, 32'h00);
		bus(1'b0, TSBD_REF_BIAS_CONFIG_ADDR, 32'h0, 1'b0);
		chk("bias_cfg_rst", rq, 32'h40);
		outs();
		for (int k = 0; k < 12; k++) begin
			l = lfsr(l);
			raw = k[0];
			bus(1'b1, TSBD_TEST_SIGNAL_CONFIG_ADDR, l, raw);
			t_m = (raw ? l[7:0] : (l[7:0] & 8'h37) | 8'h20) & 8'h37;
			bus(1'b1, TSBD_REF_BIAS_CONFIG_ADDR, l >> 8, raw);
			b_m = (l[15:8] & 8'hBE) | 8'h40;
			for (int i = 0; i < TSBD_NUM_CH; i++) mux[i] <= (i == 0) ? 3'h2 : l[i+:3];
			bus(1'b0, TSBD_TEST_SIGNAL_CONFIG_ADDR, 32'h0, 1'b0);
			chk("test_cfg_rd", rq, t_m);
			bus(1'b0, TSBD_REF_BIAS_CONFIG_ADDR, 32'h0, 1'b0);
			chk("bias_cfg_rd", rq, b_m);
			outs();
		end
		bus(1'b1, TSBD_REF_BIAS_CONFIG_ADDR, 32'h02, 1'b0);
		bus(1'b1, TSBD_IRQ_ENABLE_ADDR, 32'h1, 1'b0);
		off_in <= 1'b1;
		repeat (3) @(posedge pclk);
		bus(1'b1, TSBD_REF_BIAS_CONFIG_ADDR, 32'h02, 1'b1);
		bus(1'b0, TSBD_REF_BIAS_CONFIG_ADDR, 32'h0, 1'b0);
		chk("status_set", rq, 32'h43);
		#1;
		chk("disc_pin", disc, 1'b1);
		bus(1'b0, TSBD_IRQ_STATUS_ADDR, 32'h0, 1'b0);
		chk("irq_status", rq, 32'h1);
		#1;
		chk("irq_on", irq, 1'b1);
		bus(1'b1, TSBD_IRQ_CLEAR_ADDR, 32'h1, 1'b0);
		off_in <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		chk("irq_masked", irq, 1'b0);
		bus(1'b0, TSBD_IRQ_STATUS_ADDR, 32'h0, 1'b0);
		chk("irq_conn", rq, 32'h2);
		bus(1'b1, TSBD_TEST_SIGNAL_CONFIG_ADDR, 32'h33, 1'b0);
		repeat (3) @(posedge pclk);
		#1;
		chk("wave_dc", wave, 1'b1);
		bus(1'b1, TSBD_TEST_SIGNAL_CONFIG_ADDR, 32'h12, 1'b1);
		repeat (3) @(posedge pclk);
		#1;
		chk("wave_unused", wave, 1'b0);
		bus(1'b1, TSBD_TEST_SIGNAL_CONFIG_ADDR, 32'h23, 1'b0);
		repeat (3) @(posedge pclk);
		#1;
		chk("wave_ext", wave, 1'b0);
		bus(1'b0, 12'h040, 32'h0, 1'b0);
		chk("unmapped", {re, rq}, {1'b1, 32'h0});
		finish_test();
	end
endmodule
`default_nettype wire
